/* File: inc/cpo_pkg.sv */
// package for the compare output and pwm unit: map, fields, codes and carriers
package cpo_pkg;
    localparam int AXI_ADDR_W = 8;
    localparam int NUM_TMR = 3;
    localparam int DUTY_W = 10;
    // narrow timers advance at a quarter of aclk
    localparam int QUARTER_DIV = 4;
    localparam logic [1:0] QUARTER_LAST = 2'(QUARTER_DIV - 1);

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DUTY_LO = 8'h04;
    localparam logic [7:0] OFF_DUTY_HI = 8'h08;
    localparam logic [7:0] OFF_TSEL = 8'h0C;
    localparam logic [7:0] OFF_PIN_DIR = 8'h10;
    localparam logic [7:0] OFF_PERIOD0 = 8'h14;
    localparam logic [7:0] OFF_TCTL0 = 8'h20;
    localparam logic [7:0] OFF_FLAGS = 8'h2C;
    localparam logic [7:0] OFF_TBASE = 8'h30;

    // field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_FMT_BIT = 4;
    localparam int TCTL_ON_BIT = 2;

    // reset values
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic RST_PIN_DIR = 1'b1;

    // mode field codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOG_A = 4'h1;
    localparam logic [3:0] MODE_TOG_B = 4'h2;
    localparam logic [3:0] MODE_SET = 4'h8;
    localparam logic [3:0] MODE_CLR = 4'h9;
    localparam logic [3:0] MODE_SOFT = 4'hA;
    localparam logic [3:0] MODE_TRIG = 4'hB;
    localparam logic [3:0] MODE_PWM = 4'hF;

    // prescale codes
    localparam logic [1:0] TIMER_PRESCALE_FIELD_1 = 2'h0;
    localparam logic [1:0] TIMER_PRESCALE_FIELD_4 = 2'h1;
    localparam logic [1:0] TIMER_PRESCALE_FIELD_16 = 2'h2;
    localparam logic [1:0] TIMER_PRESCALE_FIELD_64 = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic en;
        logic fmt;
        logic [3:0] mode;
    } cpo_ctrl_t;

    typedef struct packed {
        logic on;
        logic [1:0] timer_prescale_field;
    } cpo_tmr_cfg_t;
endpackage

/* File: verilog/cpo_narrow_timer.sv */
// 8-bit auto-reload time base with prescaler, clocked at a quarter of aclk
`timescale 1ns/1ns
`default_nettype none
module cpo_narrow_timer
    import cpo_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire cpo_tmr_cfg_t cfg,
    input wire logic [7:0] period,
    output logic [7:0] count,
    output logic [1:0] low2,
    output logic period_end
);
    typedef struct packed {
        logic [1:0] phase;
        logic [5:0] pre;
        logic [7:0] cnt;
    } cpo_tmr_state_t;

    cpo_tmr_state_t s_r;
    cpo_tmr_state_t s_nxt;
    logic [5:0] limit;
    logic quarter;
    logic inc;

    // phase runs free so the 1:1 time base always has valid low bits
    always_comb begin
        unique case (cfg.timer_prescale_field)
            TIMER_PRESCALE_FIELD_1: limit = 6'h00;
            TIMER_PRESCALE_FIELD_4: limit = 6'h03;
            TIMER_PRESCALE_FIELD_16: limit = 6'h0F;
            TIMER_PRESCALE_FIELD_64: limit = 6'h3F;
        endcase
        quarter = (s_r.phase == QUARTER_LAST);
        inc = cfg.on && quarter && (s_r.pre == limit);
        period_end = inc && (s_r.cnt == period);
        s_nxt = s_r;
        s_nxt.phase = s_r.phase + 2'h1;
        if (cfg.on && quarter) begin
            s_nxt.pre = inc ? 6'h00 : s_r.pre + 6'h01;
        end
        if (inc) begin
            s_nxt.cnt = period_end ? 8'h00 : s_r.cnt + 8'h01;
        end
        // low two time base bits follow clock phase or prescaler
        unique case (cfg.timer_prescale_field)
            TIMER_PRESCALE_FIELD_1: low2 = s_r.phase;
            TIMER_PRESCALE_FIELD_4: low2 = s_r.pre[1:0];
            TIMER_PRESCALE_FIELD_16: low2 = s_r.pre[3:2];
            TIMER_PRESCALE_FIELD_64: low2 = s_r.pre[5:4];
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.cnt;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reload_to_zero: assert property (period_end |=> s_r.cnt == 8'h00)
        else $error("timer did not clear after period end");
    a_quarter_rate: assert property (inc |=> !inc [*3])
        else $error("timer advanced faster than a quarter of aclk");
endmodule
`default_nettype wire

/* File: verilog/cpo_unit.sv */
// compare output and standard pwm unit with axi4-lite register access
// Behaviour
// - trigger and soft-interrupt modes: output high while wide timer equals compare pair
// - toggle modes: output inverts on each match
// - clear mode: output goes low on match
// - set mode: output goes high on match
// - unit output feeds peripherals and the pin
// - pwm mode makes a pwm signal of up to 10 bits
// - each unit selects its own narrow timer as pwm time base
// - period is (period reg + 1) times 4 clocks times prescale
// - at period end: timer clears, duty latched, output set unless duty zero
// - alignment bit picks where the 10 duty bits sit in high and low regs
// - duty regs writable anytime, take effect only at period end
// - 10-bit time base is timer plus clock phase or prescaler bits
// - time base equal to buffered duty drives pwm output low
// - high time is duty times clock times prescale
// - duty above period never clears, output keeps its level
// - postscaler has no effect on pwm period
// - all-zero control register releases the pin
// - resolution is log2 of 4 times (period + 1), 10 bits at 255
// - all-zero control register forces the compare latch low
`timescale 1ns/1ns
`default_nettype none
module cpo_unit
    import cpo_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] wide_timer_count,
    output logic unit_out,
    output logic pin_out,
    output logic pin_oe
);
    typedef struct packed {
        cpo_ctrl_t ctrl;
        logic [7:0] duty_lo;
        logic [7:0] duty_hi;
        logic [1:0] tsel;
        logic pin_dir;
        logic [NUM_TMR-1:0][7:0] period;
        logic [NUM_TMR-1:0][2:0] tcfg;
        logic [NUM_TMR-1:0] flags;
        logic [DUTY_W-1:0] duty_buf;
        logic start;
        logic cmp;
        logic pwm;
        logic out;
        logic match_d;
        logic aw_got;
        logic w_got;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cpo_state_t;

    cpo_state_t s_r;
    cpo_state_t s_nxt;

    logic [NUM_TMR-1:0][7:0] tmr_count;
    logic [NUM_TMR-1:0][1:0] tmr_low2;
    logic [NUM_TMR-1:0] tmr_end;
    logic [1:0] sel;
    logic [DUTY_W-1:0] timebase;
    logic [DUTY_W-1:0] duty_value;
    logic period_end_sel;
    logic match;
    logic match_rise;
    logic pwm_mode;
    logic ctrl_zero;
    logic commit;
    logic wr_ctrl;
    logic [5:0] wword;

    // word index of a byte address, shared by write and read decode
    function automatic logic [5:0] word_of(input logic [AXI_ADDR_W-1:0] a);
        word_of = a[7:2];
    endfunction

    // timer select code 3 is spare and falls back to timer 0
    function automatic logic [1:0] timer_idx(input logic [1:0] t);
        timer_idx = (t == 2'h3) ? 2'h0 : t;
    endfunction

    // read mux; unmapped words answer slverr with zero data
    function automatic logic [32:0] read_word(input cpo_state_t s,
                                              input logic [5:0] w,
                                              input logic [DUTY_W-1:0] tb);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        if (w == OFF_CTRL[7:2]) begin
            r[CTRL_EN_BIT] = s.ctrl.en;
            r[CTRL_OUT_BIT] = s.out;
            r[CTRL_FMT_BIT] = s.ctrl.fmt;
            r[3:0] = s.ctrl.mode;
        end else if (w == OFF_DUTY_LO[7:2]) begin
            r[7:0] = s.duty_lo;
        end else if (w == OFF_DUTY_HI[7:2]) begin
            r[7:0] = s.duty_hi;
        end else if (w == OFF_TSEL[7:2]) begin
            r[1:0] = s.tsel;
        end else if (w == OFF_PIN_DIR[7:2]) begin
            r[0] = s.pin_dir;
        end else if (w == OFF_FLAGS[7:2]) begin
            r[NUM_TMR-1:0] = s.flags;
        end else if (w == OFF_TBASE[7:2]) begin
            r[DUTY_W-1:0] = tb;
        end else begin
            r[32] = 1'b1;
            for (int i = 0; i < NUM_TMR; i++) begin
                if (w == 6'(OFF_PERIOD0[7:2] + i)) begin
                    r = {1'b0, 24'h000000, s.period[i]};
                end
                if (w == 6'(OFF_TCTL0[7:2] + i)) begin
                    r = {1'b0, 29'h00000000, s.tcfg[i]};
                end
            end
        end
        read_word = r;
    endfunction

    // three narrow timers; each unit picks one independently
    for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
        cpo_narrow_timer u_tmr (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg(cpo_tmr_cfg_t'(s_r.tcfg[g])),
            .period(s_r.period[g]),
            .count(tmr_count[g]),
            .low2(tmr_low2[g]),
            .period_end(tmr_end[g])
        );
    end

    // time base and duty decode of the selected timer
    always_comb begin
        sel = timer_idx(s_r.tsel);
        timebase = {tmr_count[sel], tmr_low2[sel]};
        // period end comes from the reload itself, never from a postscaler
        period_end_sel = tmr_end[sel];
        if (s_r.ctrl.fmt) begin
            duty_value = {s_r.duty_hi, s_r.duty_lo[7:6]};
        end else begin
            duty_value = {s_r.duty_hi[1:0], s_r.duty_lo};
        end
        match = (wide_timer_count == {s_r.duty_hi, s_r.duty_lo});
        match_rise = match && !s_r.match_d;
        pwm_mode = (s_r.ctrl.mode == MODE_PWM);
        ctrl_zero = (s_r.ctrl == '0);
        commit = s_r.aw_got && s_r.w_got;
        wword = word_of(s_r.awaddr);
        wr_ctrl = commit && s_r.wstrb0 && (wword == OFF_CTRL[7:2]);
    end

    // whole next state: bus slave, registers, compare and pwm
    always_comb begin
        logic [32:0] rd;
        logic [NUM_TMR-1:0] clr;
        rd = '0;
        clr = '0;
        s_nxt = s_r;

        // write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata[7:0];
            s_nxt.wstrb0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // only byte lane 0 holds data; other lanes are ignored
        if (commit) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            rd = read_word(s_r, wword, timebase);
            s_nxt.bresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
            if (s_r.wstrb0) begin
                if (wword == OFF_CTRL[7:2]) begin
                    s_nxt.ctrl.en = s_r.wdata[CTRL_EN_BIT];
                    s_nxt.ctrl.fmt = s_r.wdata[CTRL_FMT_BIT];
                    s_nxt.ctrl.mode = s_r.wdata[3:0];
                end
                // duty writes land in the staging regs at any time
                if (wword == OFF_DUTY_LO[7:2]) begin
                    s_nxt.duty_lo = s_r.wdata;
                end
                if (wword == OFF_DUTY_HI[7:2]) begin
                    s_nxt.duty_hi = s_r.wdata;
                end
                if (wword == OFF_TSEL[7:2]) begin
                    s_nxt.tsel = s_r.wdata[1:0];
                end
                if (wword == OFF_PIN_DIR[7:2]) begin
                    s_nxt.pin_dir = s_r.wdata[0];
                end
                if (wword == OFF_FLAGS[7:2]) begin
                    clr = s_r.wdata[NUM_TMR-1:0];
                end
                for (int i = 0; i < NUM_TMR; i++) begin
                    if (wword == 6'(OFF_PERIOD0[7:2] + i)) begin
                        s_nxt.period[i] = s_r.wdata;
                    end
                    if (wword == 6'(OFF_TCTL0[7:2] + i)) begin
                        s_nxt.tcfg[i] = s_r.wdata[TCTL_ON_BIT:0];
                    end
                end
            end
        end

        // read answers one cycle after the address is taken
        if (s_axi_rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rd = read_word(s_r, word_of(s_axi_araddr), timebase);
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd[31:0];
            s_nxt.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
        end

        // overflow flags: a set in the clearing cycle wins
        s_nxt.flags = (s_r.flags & ~clr) | tmr_end;

        // compare output latch
        s_nxt.match_d = match;
        if (ctrl_zero) begin
            s_nxt.cmp = 1'b0;
        end else begin
            unique case (s_r.ctrl.mode)
                MODE_TRIG, MODE_SOFT: s_nxt.cmp = match;
                MODE_TOG_A, MODE_TOG_B: begin
                    // edge only: the timer may sit on the match for many clocks
                    if (match_rise) begin
                        s_nxt.cmp = !s_r.cmp;
                    end
                end
                MODE_CLR: begin
                    if (match) begin
                        s_nxt.cmp = 1'b0;
                    end
                end
                MODE_SET: begin
                    if (match) begin
                        s_nxt.cmp = 1'b1;
                    end
                end
                default: s_nxt.cmp = s_r.cmp;
            endcase
        end

        // pwm: double-buffered duty, set at period start, clear on match
        s_nxt.start = period_end_sel;
        if (period_end_sel) begin
            s_nxt.duty_buf = duty_value;
        end
        if (!pwm_mode) begin
            s_nxt.pwm = 1'b0;
        end else if (timebase == s_r.duty_buf) begin
            s_nxt.pwm = 1'b0;
        end else if (s_r.start) begin
            // duty above the period never matches, so the level holds
            s_nxt.pwm = (s_r.duty_buf != '0);
        end

        s_nxt.out = pwm_mode ? s_nxt.pwm : s_nxt.cmp;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.pin_dir <= RST_PIN_DIR;
            s_r.period <= {NUM_TMR{RST_PERIOD}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // bus handshakes and pin drive
    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign unit_out = s_r.out;
    assign pin_out = s_r.out;
    // trigger and soft modes never claim the pin
    assign pin_oe = !ctrl_zero && s_r.ctrl.en && !s_r.pin_dir
                    && (s_r.ctrl.mode != MODE_TRIG)
                    && (s_r.ctrl.mode != MODE_SOFT);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pulse_follows: assert property (
        (!ctrl_zero && (s_r.ctrl.mode == MODE_TRIG || s_r.ctrl.mode == MODE_SOFT) && !wr_ctrl)
        |=> s_r.cmp == $past(match))
        else $error("pulse output does not follow match");
    a_toggle_match: assert property (
        (!ctrl_zero && s_r.ctrl.mode == MODE_TOG_A && match_rise && !wr_ctrl)
        |=> s_r.cmp != $past(s_r.cmp))
        else $error("toggle output did not invert");
    a_clear_match: assert property (
        (!ctrl_zero && s_r.ctrl.mode == MODE_CLR && match && !wr_ctrl) |=> !s_r.cmp)
        else $error("clear mode left output high");
    a_set_match: assert property (
        (!ctrl_zero && s_r.ctrl.mode == MODE_SET && match && !wr_ctrl) |=> s_r.cmp)
        else $error("set mode left output low");
    a_zero_release: assert property (ctrl_zero |-> !pin_oe ##1 !s_r.cmp)
        else $error("zero control still drives pin or latch");
    a_duty_latch: assert property (
        period_end_sel |=> s_r.duty_buf == $past(duty_value))
        else $error("duty not latched at period end");
    a_duty_hold: assert property (!period_end_sel |=> $stable(s_r.duty_buf))
        else $error("duty buffer changed mid period");
    a_pwm_set: assert property (
        (pwm_mode && s_r.start && s_r.duty_buf != '0 && timebase != s_r.duty_buf)
        |=> s_r.pwm ##1 (s_r.ctrl.mode != MODE_PWM || s_r.out == s_r.pwm))
        else $error("pwm not set at period start");
    a_pwm_clear: assert property ((pwm_mode && timebase == s_r.duty_buf) |=> !s_r.pwm)
        else $error("pwm not cleared on duty match");
    a_resp_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped early");

    c_pwm_period: cover property (pwm_mode && s_r.start && s_r.duty_buf != '0);
    c_toggle: cover property (s_r.ctrl.mode == MODE_TOG_B && match_rise);
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_duty_over: cover property (pwm_mode && s_r.start && s_r.pwm);
endmodule
`default_nettype wire

/* File: testbench/cpo_wide_timer_model.sv */
// behavioural model of the 16-bit timer that feeds the compare pair match
`timescale 1ns/1ns
`default_nettype none
module cpo_wide_timer_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_val,
    output logic [15:0] count
);
    // stops when not running so the bench can hold a match level for a while
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 16'h0000;
        end else if (load) begin
            count <= load_val;
        end else if (run) begin
            count <= count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb_compare_output_and_pwm.sv */
// self-checking bench for the compare output and pwm unit
`timescale 1ns/1ns
`default_nettype none
module tb_compare_output_and_pwm;
    import cpo_pkg::*;
    typedef struct packed {
        logic [1:0] ts;
        logic [7:0] per;
        logic [1:0] ck;
        logic fmt;
        logic [7:0] hi;
        logic [7:0] lo;
        int duty_clks;
        int per_clks;
    } cpo_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, unit_out, pin_out, pin_oe;
    logic [1:0] bresp, rresp, rs, bs;
    logic [31:0] rdata, rd;
    logic run = 1'b0;
    logic load = 1'b0;
    logic [15:0] load_val = 16'h0000;
    logic [15:0] wcount;
    int error_cnt = 0;
    int samples_checked = 0;
    int hc, pc, n;
    logic [7:0] ra [6] = '{OFF_CTRL, OFF_DUTY_HI, OFF_PIN_DIR, 8'h1C, OFF_TCTL0, 8'h34};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h00};
    logic [3:0] cm [4] = '{MODE_TOG_A, MODE_TOG_B, MODE_SOFT, MODE_TRIG};
    // window counts need no edge alignment, so any phase of the timer works
    cpo_row_t rows [8] = '{
        '{2'h0, 8'h03, TIMER_PRESCALE_FIELD_1, 1'b0, 8'h00, 8'h05, 5, 16},
        '{2'h0, 8'h03, TIMER_PRESCALE_FIELD_1, 1'b1, 8'h01, 8'h80, 6, 16},
        '{2'h1, 8'h07, TIMER_PRESCALE_FIELD_1, 1'b0, 8'h00, 8'h00, 0, 32},
        '{2'h1, 8'h07, TIMER_PRESCALE_FIELD_4, 1'b0, 8'h00, 8'h09, 36, 128},
        '{2'h2, 8'h01, TIMER_PRESCALE_FIELD_1, 1'b0, 8'h00, 8'h14, 8, 8},
        '{2'h2, 8'h01, TIMER_PRESCALE_FIELD_16, 1'b1, 8'h01, 8'h00, 64, 128},
        '{2'h2, 8'h01, TIMER_PRESCALE_FIELD_64, 1'b0, 8'h00, 8'h04, 256, 512},
        '{2'h0, 8'hFF, TIMER_PRESCALE_FIELD_1, 1'b0, 8'h03, 8'hFF, 1023, 1024}};

    always #4 aclk = ~aclk;

    cpo_wide_timer_model wtm (.aclk(aclk), .aresetn(aresetn), .run(run), .load(load),
        .load_val(load_val), .count(wcount));

    cpo_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .wide_timer_count(wcount), .unit_out(unit_out),
        .pin_out(pin_out), .pin_oe(pin_oe));

    task print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task hang();
        chk(1'b0, "wait ran out");
        print_verdict();
    endtask

    // handshakes are judged at the falling edge, released right after the rising one
    task axi_wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_hit, w_hit, b_hit;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'h7;
        // local flag: the valids above are not updated yet in this time step
        b_hit = 1'b0;
        for (n = 0; n < 50 && !b_hit; n++) begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bready && bvalid;
            if (b_hit) bs = bresp;
            @(posedge aclk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (b_hit) bready <= 1'b0;
        end
        if (!b_hit) hang();
    endtask

    task axi_rd(input logic [7:0] a);
        logic ar_hit, r_hit;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        r_hit = 1'b0;
        for (n = 0; n < 50 && !r_hit; n++) begin
            @(negedge aclk);
            ar_hit = arvalid && arready;
            r_hit = rready && rvalid;
            if (r_hit) {rd, rs} = {rdata, rresp};
            @(posedge aclk);
            if (ar_hit) arvalid <= 1'b0;
            if (r_hit) rready <= 1'b0;
        end
        if (!r_hit) hang();
    endtask

    task cnt(input int k);
        {hc, pc} = 64'h0;
        repeat (k) begin
            @(negedge aclk);
            if (unit_out === 1'b1) hc++;
            if (pin_out === 1'b1) pc++;
        end
    endtask

    task tmr(input logic [15:0] v);
        @(posedge aclk);
        {load, load_val} <= {1'b1, v};
        @(posedge aclk);
        load <= 1'b0;
        cnt(3);
    endtask

    // main sequence: reset map, setup order, pwm table, then compare modes
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            axi_rd(ra[i]);
            chk(rd === {24'h000000, rv[i]} && rs === (i == 5 ? RESP_SLVERR : RESP_OKAY), "reset map");
        end
        axi_wr(OFF_TCTL0, 8'h04);
        chk(bs === RESP_OKAY, "write response okay");
        axi_wr(8'h34, 8'h00);
        chk(bs === RESP_SLVERR, "unmapped write response");
        for (hc = 0; hc < 1000 && rd[0] !== 1'b1; hc++) axi_rd(OFF_FLAGS);
        chk(rd[0] === 1'b1, "no overflow flag");
        axi_wr(OFF_FLAGS, 8'h01);
        axi_wr(OFF_PIN_DIR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            axi_wr(OFF_PERIOD0 + {4'h0, rows[i].ts, 2'h0}, rows[i].per);
            axi_wr(OFF_TCTL0 + {4'h0, rows[i].ts, 2'h0}, {5'h00, 1'b1, rows[i].ck});
            axi_wr(OFF_TSEL, {6'h00, rows[i].ts});
            axi_wr(OFF_CTRL, {3'h4, rows[i].fmt, MODE_PWM});
            axi_wr(OFF_DUTY_HI, rows[i].hi);
            axi_wr(OFF_DUTY_LO, rows[i].lo);
            cnt(3 * rows[i].per_clks + 1024); // a shrunk period may first wrap the count
            cnt(4 * rows[i].per_clks);
            chk(hc === 4 * rows[i].duty_clks, "pwm high time");
            chk(pc === hc && pin_oe === 1'b1, "pin follows unit");
        end
        axi_wr(OFF_CTRL, 8'h00);
        axi_wr(OFF_DUTY_HI, 8'h12);
        axi_wr(OFF_DUTY_LO, 8'h34);
        tmr(16'h0000);
        axi_wr(OFF_CTRL, {4'h8, MODE_SET});
        tmr(16'h1234);
        chk(unit_out === 1'b1 && pin_oe === 1'b1, "set on match");
        tmr(16'h0000);
        axi_wr(OFF_CTRL, {4'h8, MODE_CLR});
        chk(unit_out === 1'b1, "clear without match");
        tmr(16'h1234);
        chk(unit_out === 1'b0, "clear on match");
        // toggles need fresh matches; pulse modes see one matching cycle
        for (int i = 0; i < 4; i++) begin
            axi_wr(OFF_CTRL, {4'h8, cm[i]});
            if (i < 2) begin
                tmr(16'h0000);
                tmr(16'h1234);
                chk(unit_out === 1'b1, "toggle up");
                tmr(16'h0000);
                tmr(16'h1234);
                chk(unit_out === 1'b0, "toggle down");
            end else begin
                tmr(16'h1230);
                run <= 1'b1;
                cnt(20);
                run <= 1'b0;
                chk(hc === 1 && pin_oe === 1'b0, "pulse while match");
            end
        end
        axi_wr(OFF_CTRL, {4'h8, MODE_SET});
        tmr(16'h1234);
        axi_wr(OFF_CTRL, 8'h00);
        cnt(3);
        chk(unit_out === 1'b0 && pin_oe === 1'b0, "zero control");
        // mid-run reset with the pin driven: outputs idle, pin direction register back to reset
        axi_wr(OFF_CTRL, {4'h8, MODE_SET});
        tmr(16'h1234);
        chk(unit_out === 1'b1 && pin_oe === 1'b1, "set before reset");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        cnt(2);
        chk(unit_out === 1'b0 && pin_oe === 1'b0 && awready === 1'b1, "reset outputs");
        axi_rd(OFF_PIN_DIR);
        chk(rd === 32'h00000001 && rs === RESP_OKAY, "pin direction reset");
        print_verdict();
    end
endmodule
`default_nettype wire
